// >>> logic/pprt_defines.vh
// Constants for the peripheral pin input router: map, defaults and port masks
// Notes on behaviour
// - Only digital signals are routed; analog stays on fixed pins.
// - Input and output selections are independent register sets.
// - Each peripheral input has its own select register choosing its pin.
// - Each pin has its own output select; code 0x0c is UART1 transmit.
// - Code 0x17 in the UART1 receive select routes port C bit 7.
// - Several inputs may share one pin; all see it at once, unarbitrated.
// - Port level reads return the real pin level, whatever the routing.
// - Each input accepts pins only from its own small set of ports.
// - Power-on reset loads each input select with its default pin code.
// - Only power-on reset restores selections; other resets keep them.
`ifndef PPRT_DEFINES_VH
`define PPRT_DEFINES_VH

// ==========================================================================
// Geometry
`define PPRT_NUM_PINS        64
`define PPRT_NUM_INPUTS      16
`define PPRT_NUM_PORTS       8
`define PPRT_SEL_W           6
`define PPRT_NUM_OUT_SRC     33
`define PPRT_MAX_OUT_CODE    6'h21
`define PPRT_OUT_CODE_LATCH  6'h00

// ==========================================================================
// APB map, region number in address bits 11:8
`define PPRT_IN_SEL_BASE     4'h0
`define PPRT_OUT_SEL_BASE    4'h1
`define PPRT_PORT_LVL_BASE   4'h2

// ==========================================================================
// Input select reset codes
`define PPRT_DEF_EXT_IRQ0    6'h08
`define PPRT_DEF_EXT_IRQ1    6'h09
`define PPRT_DEF_EXT_IRQ2    6'h0a
`define PPRT_DEF_EXT_IRQ3    6'h0b
`define PPRT_DEF_TMR0_CLK    6'h04
`define PPRT_DEF_TMR1_CLK    6'h10
`define PPRT_DEF_TMR3_GATE   6'h05
`define PPRT_DEF_ADC_TRIG    6'h39
`define PPRT_DEF_CAPT1       6'h25
`define PPRT_DEF_SER1_CLK    6'h13
`define PPRT_DEF_SER1_DATA   6'h14
`define PPRT_DEF_SER1_SS     6'h2f
`define PPRT_DEF_UART1_RECV  6'h17
`define PPRT_DEF_UART1_CLK   6'h16
`define PPRT_DEF_UART5_RECV  6'h23
`define PPRT_DEF_UART5_CLK   6'h22

// ==========================================================================
// Permitted ports per input, bit 0 = port A
`define PPRT_MSK_EXT_IRQ0    8'h03
`define PPRT_MSK_EXT_IRQ1    8'h06
`define PPRT_MSK_EXT_IRQ2    8'h0a
`define PPRT_MSK_EXT_IRQ3    8'h12
`define PPRT_MSK_TMR0_CLK    8'h03
`define PPRT_MSK_TMR1_CLK    8'h0c
`define PPRT_MSK_TMR3_GATE   8'h05
`define PPRT_MSK_ADC_TRIG    8'h84
`define PPRT_MSK_CAPT1       8'h14
`define PPRT_MSK_SER1_CLK    8'h06
`define PPRT_MSK_SER1_DATA   8'h06
`define PPRT_MSK_SER1_SS     8'h22
`define PPRT_MSK_UART1_RECV  8'h0c
`define PPRT_MSK_UART1_CLK   8'h0c
`define PPRT_MSK_UART5_RECV  8'h50
`define PPRT_MSK_UART5_CLK   8'h50

`endif

// >>> logic/pprt_in_chan.v
// One peripheral input channel: its select register and its pin mux
`timescale 1ns/1ps
`default_nettype none
`include "pprt_defines.vh"

module pprt_in_chan #(
  parameter [5:0] RESET_CODE = 6'h00,
  parameter [7:0] PORT_MASK  = 8'hff
) (
  // Clock and power-on reset
  input  wire        pclk,
  input  wire        presetn,
  // Register write
  input  wire        wr_en,
  input  wire [5:0]  wdata,
  // Digital pin levels and result
  input  wire [63:0] pins,
  output reg  [5:0]  sel,
  output reg         routed
);

  // ========================================================================
  // Selection register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel <= RESET_CODE;
    end else if (wr_en) begin
      sel <= wdata;
    end
  end

  // ========================================================================
  // Pin mux; a code outside the permitted ports is stored but drives low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routed <= 1'b0;
    end else if (PORT_MASK[sel[5:3]]) begin
      routed <= pins[sel];
    end else begin
      routed <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> logic/pprt_top.v
// Peripheral pin router: APB registers, input routing and output routing
`timescale 1ns/1ps
`default_nettype none
`include "pprt_defines.vh"

module pprt_top (
  // Clock and power-on reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // Pins, index = port * 8 + bit
  input  wire [63:0] pin_in,
  input  wire [63:0] analog_select_bit,
  input  wire [63:0] port_latch,
  output reg  [63:0] pin_out,
  // Peripheral side
  input  wire [32:0] periph_out,
  output wire [15:0] periph_in
);

  // ========================================================================
  // Channel table
  // Constant functions keep each channel's default next to its port mask.
  function [5:0] chan_default;
    input integer idx;
    begin
      case (idx)
        0:       chan_default = `PPRT_DEF_EXT_IRQ0;
        1:       chan_default = `PPRT_DEF_EXT_IRQ1;
        2:       chan_default = `PPRT_DEF_EXT_IRQ2;
        3:       chan_default = `PPRT_DEF_EXT_IRQ3;
        4:       chan_default = `PPRT_DEF_TMR0_CLK;
        5:       chan_default = `PPRT_DEF_TMR1_CLK;
        6:       chan_default = `PPRT_DEF_TMR3_GATE;
        7:       chan_default = `PPRT_DEF_ADC_TRIG;
        8:       chan_default = `PPRT_DEF_CAPT1;
        9:       chan_default = `PPRT_DEF_SER1_CLK;
        10:      chan_default = `PPRT_DEF_SER1_DATA;
        11:      chan_default = `PPRT_DEF_SER1_SS;
        12:      chan_default = `PPRT_DEF_UART1_RECV;
        13:      chan_default = `PPRT_DEF_UART1_CLK;
        14:      chan_default = `PPRT_DEF_UART5_RECV;
        default: chan_default = `PPRT_DEF_UART5_CLK;
      endcase
    end
  endfunction

  function [7:0] chan_mask;
    input integer idx;
    begin
      case (idx)
        0:       chan_mask = `PPRT_MSK_EXT_IRQ0;
        1:       chan_mask = `PPRT_MSK_EXT_IRQ1;
        2:       chan_mask = `PPRT_MSK_EXT_IRQ2;
        3:       chan_mask = `PPRT_MSK_EXT_IRQ3;
        4:       chan_mask = `PPRT_MSK_TMR0_CLK;
        5:       chan_mask = `PPRT_MSK_TMR1_CLK;
        6:       chan_mask = `PPRT_MSK_TMR3_GATE;
        7:       chan_mask = `PPRT_MSK_ADC_TRIG;
        8:       chan_mask = `PPRT_MSK_CAPT1;
        9:       chan_mask = `PPRT_MSK_SER1_CLK;
        10:      chan_mask = `PPRT_MSK_SER1_DATA;
        11:      chan_mask = `PPRT_MSK_SER1_SS;
        12:      chan_mask = `PPRT_MSK_UART1_RECV;
        13:      chan_mask = `PPRT_MSK_UART1_CLK;
        14:      chan_mask = `PPRT_MSK_UART5_RECV;
        default: chan_mask = `PPRT_MSK_UART5_CLK;
      endcase
    end
  endfunction

  // ========================================================================
  // Address decode
  wire        aligned;
  wire [3:0]  region;
  wire [5:0]  word;
  wire        hit_in;
  wire        hit_out;
  wire        hit_lvl;
  wire        hit_any;
  wire        wr_ok;
  wire        setup;
  wire        access;

  assign aligned = (paddr[1:0] == 2'b00);
  assign region  = paddr[11:8];
  assign word    = paddr[7:2];
  assign hit_in  = aligned && (region == `PPRT_IN_SEL_BASE) &&
                   (word < 6'd16);
  assign hit_out = aligned && (region == `PPRT_OUT_SEL_BASE);
  assign hit_lvl = aligned && (region == `PPRT_PORT_LVL_BASE) &&
                   (word < 6'd8);
  assign hit_any = hit_in || hit_out || hit_lvl;
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  // Port level words are read only; a write there is refused
  assign wr_ok   = access && pwrite && (hit_in || hit_out);

  // Zero wait states: read data is fetched in the setup cycle
  assign pready = 1'b1;

  // ========================================================================
  // Digital input buffer
  // Analog functions never enter this block; with the analog select set the
  // buffer reads low, so software must clear it before routing a pin.
  wire [63:0] dig_in;

  assign dig_in = pin_in & ~analog_select_bit;

  // ========================================================================
  // Input routing, one channel per peripheral input
  wire [95:0] in_sel_bus;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_in
      pprt_in_chan #(
        .RESET_CODE (chan_default(gi)),
        .PORT_MASK  (chan_mask(gi))
      ) u_chan (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_ok && hit_in && (word == gi)),
        .wdata   (pwdata[5:0]),
        .pins    (dig_in),
        .sel     (in_sel_bus[gi*6 +: 6]),
        .routed  (periph_in[gi])
      );
    end
  endgenerate

  // ========================================================================
  // Output selection registers, one per pin
  reg [5:0] out_sel [0:63];
  integer   pi;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (pi = 0; pi < 64; pi = pi + 1) begin
        out_sel[pi] <= `PPRT_OUT_CODE_LATCH;
      end
    end else if (wr_ok && hit_out) begin
      out_sel[word] <= pwdata[5:0];
    end
  end

  // ========================================================================
  // Output mux; unknown codes above the table drive the pin low
  reg [63:0] next_pin_out;
  reg [5:0]  osel;
  integer    po;

  always @* begin
    next_pin_out = 64'h0;
    osel         = 6'h00;
    for (po = 0; po < 64; po = po + 1) begin
      osel = out_sel[po];
      if (osel == `PPRT_OUT_CODE_LATCH) begin
        next_pin_out[po] = port_latch[po];
      end else if (osel <= `PPRT_MAX_OUT_CODE) begin
        next_pin_out[po] = periph_out[osel - 6'd1];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 64'h0;
    end else begin
      pin_out <= next_pin_out;
    end
  end

  // ========================================================================
  // Read path
  reg [31:0] rd_val;

  always @* begin
    rd_val = 32'h0;
    if (hit_in) begin
      rd_val[5:0] = in_sel_bus[word[3:0]*6 +: 6];
    end else if (hit_out) begin
      rd_val[5:0] = out_sel[word];
    end else if (hit_lvl) begin
      rd_val[7:0] = pin_in[word[2:0]*8 +: 8];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : rd_val;
      pslverr <= !hit_any || (pwrite && hit_lvl);
    end
  end

endmodule
`default_nettype wire

// >>> testbench/pprt_monitor.sv
// Checker of the router's register and routing behaviour
`timescale 1ns/1ps
`default_nettype none
`include "pprt_defines.vh"
// ==========================================================================
// Checker
module pprt_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Pins and peripherals
  input wire logic [63:0] pin_in,
  input wire logic [63:0] analog_select_bit,
  input wire logic [63:0] port_latch,
  input wire logic [63:0] pin_out,
  input wire logic [32:0] periph_out,
  input wire logic [15:0] periph_in
);
  localparam [127:0] DEF = 128'h22231617_2f141325_39051004_0b0a0908;
  logic [5:0] shd [16];
  logic [5:0] c6;
  logic [1:0] quiet;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire in_a = paddr[11:6] == 6'h00 && paddr[1:0] == 2'h0;
  wire [5:0] s12 = shd[12];
  wire [7:0] msk12 = `PPRT_MSK_UART1_RECV >> s12[5:3];
  wire ok12 = msk12[0];
  wire hit12 = pin_in[s12] & ~analog_select_bit[s12];
  wire [63:0] lvl_all = pin_in >> {paddr[4:2], 3'h0};
  wire [7:0] lvl = lvl_all[7:0];
  wire exp6 = c6 == 6'h00 ? port_latch[22] :
              c6 > 6'h21 ? 1'b0 : periph_out[c6 - 6'h01];
  // Routing is only judged once selections have settled for two edges
  wire calm = quiet == 2'h2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) shd[i] <= DEF[8*i +: 6];
      c6 <= 6'h00;
      quiet <= 2'h0;
    end else begin
      if (wr && in_a) shd[paddr[5:2]] <= pwdata[5:0];
      if (wr && paddr == 12'h158) c6 <= pwdata[5:0];
      quiet <= wr ? 2'h0 : quiet + {1'b0, quiet != 2'h2};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_insel_read: assert property (
    acc && !pwrite && in_a |-> prdata == {26'h0, shd[paddr[5:2]]})
    else $error("input select read back wrong");
  chk_port_level: assert property (
    acc && !pwrite && paddr[11:5] == 7'h10 && paddr[1:0] == 2'h0
    |-> prdata[7:0] == $past(lvl)) else $error("port level read wrong");
  chk_route_sel: assert property (
    calm && ok12 |-> periph_in[12] == $past(hit12))
    else $error("routed input wrong");
  chk_route_refuse: assert property (
    calm && !ok12 |=> !periph_in[12]) else $error("refused port routed");
  chk_analog_off: assert property (
    calm && analog_select_bit[s12] |=> !periph_in[12])
    else $error("analog pin routed");
  chk_shared_pin: assert property (
    calm && shd[13] == s12 |-> periph_in[13] == periph_in[12])
    else $error("shared pin differs");
  chk_out_route: assert property (
    calm |-> pin_out[22] == $past(exp6)) else $error("pin output wrong");
  chk_level_ro: assert property (
    wr && paddr[11:8] == 4'h2 |-> pslverr) else $error("level write taken");
  chk_insel_ok: assert property (
    acc && in_a |-> !pslverr) else $error("select access refused");
endmodule
bind pprt_top pprt_monitor mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .pslverr, .paddr, .pwdata, .prdata, .pin_in,
  .analog_select_bit, .port_latch, .pin_out, .periph_out, .periph_in);
`default_nettype wire

// >>> testbench/pprt_periph_model.sv
// Model of the on-chip peripherals feeding the pin output selectors
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Peripheral outputs
module pprt_periph_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bit k is output code k+1
  output var  logic [32:0] periph_out
);
  // Shifting pattern, so a wrong output code is seen within a few cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      periph_out <= 33'h1_2345_6789;
    else
      periph_out <= {periph_out[31:0], periph_out[32] ^ periph_out[19]};
  end
endmodule
`default_nettype wire

// >>> testbench/peripheral_pin_input_router_bench.sv
// Self-checking bench of the peripheral pin router
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
// ==========================================================================
// Bench
module peripheral_pin_input_router_bench;
  localparam [127:0] DEF = 128'h22231617_2f141325_39051004_0b0a0908;
  localparam [127:0] MSK = 128'h50500c0c_22060614_84050c03_120a0603;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, err, live = 1'b0, ana_on = 1'b1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, rs = 32'h4a;
  logic [63:0] pin_in = '0, analog = '0, latch = '0, snap, exp_out;
  logic [15:0] exp_in;
  logic [5:0] m_in [16], m_out [64];
  logic [11:0] bad [3] = '{12'h204, 12'h300, 12'h031};
  int mismatches = 0, n_tests = 0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [63:0] pin_out;
  wire [32:0] periph_out;
  wire [15:0] periph_in;
  always #5 pclk = ~pclk;
  pprt_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_in,
    .analog_select_bit(analog), .port_latch(latch), .pin_out,
    .periph_out, .periph_in);
  pprt_periph_model far (.pclk, .presetn, .periph_out);
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  always @(posedge pclk) begin
    pin_in <= {xs(), xs()};
    latch <= {xs(), xs()};
    analog <= {xs(), xs()} & {xs(), xs()} & {64{ana_on}};
  end
  // Reference model, compared with the design every cycle
  always @(posedge pclk) begin
    if (!presetn) begin
      for (int i = 0; i < 64; i++) m_out[i] <= '0;
      for (int i = 0; i < 16; i++) m_in[i] <= DEF[8*i +: 6];
      live <= 1'b0;
    end else begin
      if (live) begin
        `CHK(periph_in, exp_in)
        `CHK(pin_out, exp_out)
      end
      live <= 1'b1;
      if (psel && penable && pwrite && paddr[1:0] == 2'h0) begin
        if (paddr[11:6] == 6'h00) m_in[paddr[5:2]] <= pwdata[5:0];
        if (paddr[11:8] == 4'h1) m_out[paddr[7:2]] <= pwdata[5:0];
      end
      for (int i = 0; i < 16; i++)
        exp_in[i] <= MSK[8*i + m_in[i][5:3]] & pin_in[m_in[i]] &
                     ~analog[m_in[i]];
      for (int i = 0; i < 64; i++)
        exp_out[i] <= m_out[i] == 0 ? latch[i] :
                      m_out[i] > 6'h21 ? 1'b0 : periph_out[m_out[i] - 1];
    end
  end
  task report_and_stop();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    snap = pin_in;
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (i == 20) begin mismatches++; report_and_stop(); end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task chk_defaults();
    for (int c = 0; c < 16; c++) begin
      apb(1'b0, 12'(4 * c), '0);
      `CHK(rd, {26'h0, DEF[8*c +: 6]})
    end
  endtask
  initial begin
    int c;
    do_reset();
    chk_defaults();
    apb(1'b1, 12'h030, 32'hffff_ffd0);
    apb(1'b1, 12'h034, 32'h10);
    apb(1'b1, 12'h030, 32'h17);
    apb(1'b1, 12'h158, 32'h0c);
    for (int k = 0; k < 3; k++) begin
      apb(k != 1, bad[k], 32'h3f);
      `CHK({err, rd}, {1'b1, 32'h0})
    end
    for (int n = 0; n < 60; n++) begin
      ana_on <= n[0];
      apb(1'b1, 12'(xs() % 16 * 4), xs());
      apb(1'b1, 12'h100 + 12'(xs() % 64 * 4), xs());
      c = xs() % 16;
      apb(1'b0, 12'(4 * c), '0);
      `CHK({err, rd}, {1'b0, 26'h0, m_in[c]})
      c = xs() % 8;
      apb(1'b0, 12'h200 + 12'(4 * c), '0);
      `CHK(rd, {24'h0, snap[8*c +: 8]})
    end
    do_reset();
    chk_defaults();
    report_and_stop();
  end
endmodule
`default_nettype wire
